// file: core/afr_bank.sv
/*
  Converter function register bank: shadowed staging, commit on transfer
  command, decoded control outputs to the datapath. Assumes the serial port
  framer delivers one-cycle write and read strobes synchronous to clock.
*/
`timescale 1ns/1ps
`include "afr_cfg.svh"

module afr_bank
(
   input  wire logic            clock,          // System clock, 200 MHz.
   input  wire logic            rst,            // Asynchronous reset, active high.
   input  wire logic            clk_en,         // Freezes all state when low.
   input  wire logic            wr_en,          // Register write strobe.
   input  wire logic            rd_en,          // Register read strobe.
   input  wire logic [7:0]      addr,           // Register address.
   input  wire logic [7:0]      wr_data,        // Write data.
   output afr_pkg::afr_byte_t   rd_data,        // Read data, registered.
   output afr_pkg::afr_op_e     op_mode,        // Active chip operating mode.
   output logic                 power_standby_select, // Power-down pin meaning.
   output logic                 dcs_enable,     // Duty cycle stabilizer on.
   output afr_pkg::afr_tp_e     test_pattern,   // Active test pattern.
   output logic                 test_active,    // Test data replaces samples.
   output logic                 pn23_reset,     // Hold PN23 generator reset.
   output logic                 pn9_reset,      // Hold PN9 generator reset.
   output logic                 ain_disconnect, // Analog input disconnected.
   output logic                 common_mode_output, // Common-mode output on.
   output logic                 drv_disable,    // Output drivers off.
   output logic                 ddr_enable,     // Double data rate output.
   output logic                 out_invert,     // Output data inverted.
   output logic [1:0]           out_format,     // Output data format.
   output logic [3:0]           lvds_drive,     // Drive current setting.
   output logic                 dclk_invert,    // Data clock inverted.
   output logic                 delay_enable,   // Output delay active.
   output logic [4:0]           delay_code,     // Output delay step.
   output logic [4:0]           range_code,     // Full-scale range code.
   output logic                 ovr_enable,     // Overrange indicator on.
   output logic                 ovr_alt_pins    // Overrange on second pin pair.
);
   import afr_pkg::*;

   // -------------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------------
   function automatic logic is_shadowed(input logic [7:0] a);
      return (a >= `AFR_SHADOW_LO) && (a <= `AFR_SHADOW_HI);
   endfunction : is_shadowed

   function automatic logic [4:0] sidx(input logic [7:0] a);
      return 5'(a - `AFR_SHADOW_LO);
   endfunction : sidx

   // Only pattern codes that name a pattern are accepted; others map to off.
   function automatic afr_tp_e tp_decode(input logic [3:0] c);
      return (c <= 4'h7) ? afr_tp_e'(c) : AFR_TP_OFF;
   endfunction : tp_decode

   afr_port_if port ();
   logic [7:0] stage  [17];
   logic [7:0] active [17];
   logic [7:0] next_active [17];
   logic [7:0] ovr_cfg;
   logic [7:0] next_ovr_cfg;
   afr_byte_t  next_rd_data;
   logic       commit_pend;

   // -------------------------------------------------------------------
   // Write routing
   // -------------------------------------------------------------------
   // shadow commit decode
   // The transfer bit is never stored, so it reads back as cleared at once.
   assign commit_pend   = wr_en && addr == `AFR_ADDR_DEVICE_UPDATE &&
                          wr_data == `AFR_COMMIT_VALUE;
   assign port.wr_en    = wr_en;
   assign port.wr_addr  = addr;
   assign port.wr_data  = wr_data;
   assign port.commit   = commit_pend;

   afr_shadow u_shadow
   (
      .clock  (clock),
      .rst    (rst),
      .clk_en (clk_en),
      .port   (port.dst),
      .stage  (stage)
   );

   // -------------------------------------------------------------------
   // Active registers
   // -------------------------------------------------------------------
   // simultaneous apply
   // All shadowed bytes move together so the datapath never sees a mix.
   always_comb
   begin
      next_active = active;
      if (port.commit)
      begin
         next_active = stage;
      end
   end

   // reset preload
   // Delay and range bytes have no listed default and ride through reset.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 17; i++)
         begin
            if (i != 15 && i != 16)
            begin
               active[i] <= 8'h00;
            end
         end
         active[0]  <= `AFR_RST_POWER_MODES;
         active[1]  <= `AFR_RST_CLOCK_CONTROL;
         active[14] <= `AFR_RST_CLOCK_PHASE;
      end
      else if (clk_en)
      begin
         active <= next_active;
      end
   end

   // Overrange register sits outside the shadowed range: writes apply at once.
   always_comb
   begin
      next_ovr_cfg = ovr_cfg;
      if (wr_en && addr == `AFR_ADDR_OVERRANGE)
      begin
         next_ovr_cfg = wr_data;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ovr_cfg <= `AFR_RST_OVERRANGE;
      end
      else if (clk_en)
      begin
         ovr_cfg <= next_ovr_cfg;
      end
   end

   // -------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------
   // Shadowed reads return the staged value: the last write, unless a reset has since loaded a default; overrange reads ovr_cfg, others zero.
   always_comb
   begin
      next_rd_data = rd_data;
      if (rd_en)
      begin
         next_rd_data = 8'h00;
         if (is_shadowed(addr))
         begin
            next_rd_data = stage[sidx(addr)];
         end
         else if (addr == `AFR_ADDR_OVERRANGE)
         begin
            next_rd_data = ovr_cfg;
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rd_data <= 8'h00;
      end
      else if (clk_en)
      begin
         rd_data <= next_rd_data;
      end
   end

   // -------------------------------------------------------------------
   // Decoded control outputs
   // -------------------------------------------------------------------
   // Outputs are registered from the active copy and ovr_cfg, one cycle after the copy or ovr_cfg loads.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         op_mode              <= AFR_OP_NORMAL;
         power_standby_select <= 1'b0;
         dcs_enable           <= 1'b1;
         test_pattern         <= AFR_TP_OFF;
         test_active          <= 1'b0;
         pn23_reset           <= 1'b0;
         pn9_reset            <= 1'b0;
         ain_disconnect       <= 1'b0;
         common_mode_output   <= 1'b0;
         drv_disable          <= 1'b0;
         ddr_enable           <= 1'b0;
         out_invert           <= 1'b0;
         out_format           <= 2'h0;
         lvds_drive           <= 4'h0;
         dclk_invert          <= 1'b0;
         delay_enable         <= 1'b1;
         delay_code           <= 5'h00;
         range_code           <= 5'h00;
         ovr_enable           <= 1'b1;
         ovr_alt_pins         <= 1'b0;
      end
      else if (clk_en)
      begin
         op_mode              <= afr_op_e'(active[0][2:0]);
         power_standby_select <= active[0][`AFR_BIT_STANDBY_SEL];
         dcs_enable           <= active[1][`AFR_BIT_DCS_EN];
         test_pattern         <= tp_decode(active[5][3:0]);
         test_active          <= tp_decode(active[5][3:0]) != AFR_TP_OFF;
         pn23_reset           <= active[5][`AFR_BIT_PN23_RST];
         pn9_reset            <= active[5][`AFR_BIT_PN9_RST];
         ain_disconnect       <= active[7][`AFR_BIT_AIN_DISABLE];
         common_mode_output   <= active[7][`AFR_BIT_CM_OUT_EN];
         drv_disable          <= active[12][`AFR_BIT_DRV_DISABLE];
         ddr_enable           <= active[12][`AFR_BIT_DDR_EN];
         out_invert           <= active[12][`AFR_BIT_OUT_INVERT];
         out_format           <= active[12][1:0];
         lvds_drive           <= active[13][3:0];
         dclk_invert          <= active[14][`AFR_BIT_CLK_INVERT];
         delay_enable         <= ~active[15][`AFR_BIT_DELAY_DISABLE];
         delay_code           <= active[15][4:0];
         range_code           <= active[16][4:0];
         ovr_enable           <= ovr_cfg[`AFR_BIT_OVR_EN];
         ovr_alt_pins         <= ovr_cfg[`AFR_BIT_OVR_POS] &
                                 active[12][`AFR_BIT_DDR_EN];
      end
   end

endmodule : afr_bank

// file: core/afr_cfg.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  converter function register bank. Assumes an 8-bit address and 8-bit data
  register port driven by the serial configuration port.
*/
`ifndef AFR_CFG_SVH
`define AFR_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define AFR_ADDR_POWER_MODES    8'h08
`define AFR_ADDR_CLOCK_CONTROL  8'h09
`define AFR_ADDR_TEST_PATTERN   8'h0D
`define AFR_ADDR_ANALOG_INPUT   8'h0F
`define AFR_ADDR_OUTPUT_FORMAT  8'h14
`define AFR_ADDR_LVDS_DRIVE     8'h15
`define AFR_ADDR_CLOCK_PHASE    8'h16
`define AFR_ADDR_OUTPUT_DELAY   8'h17
`define AFR_ADDR_REF_RANGE      8'h18
`define AFR_ADDR_OVERRANGE      8'h2A
`define AFR_ADDR_DEVICE_UPDATE  8'hFF
`define AFR_SHADOW_LO           8'h08
`define AFR_SHADOW_HI           8'h18
`define AFR_COMMIT_VALUE        8'h01

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AFR_RST_POWER_MODES     8'h00
`define AFR_RST_CLOCK_CONTROL   8'h01
`define AFR_RST_TEST_PATTERN    8'h00
`define AFR_RST_ANALOG_INPUT    8'h00
`define AFR_RST_OUTPUT_FORMAT   8'h00
`define AFR_RST_LVDS_DRIVE      8'h00
`define AFR_RST_CLOCK_PHASE     8'h03
`define AFR_RST_OVERRANGE       8'h01

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AFR_BIT_STANDBY_SEL     5
`define AFR_BIT_DCS_EN          0
`define AFR_BIT_PN23_RST        5
`define AFR_BIT_PN9_RST         4
`define AFR_BIT_AIN_DISABLE     2
`define AFR_BIT_CM_OUT_EN       1
`define AFR_BIT_DRV_DISABLE     4
`define AFR_BIT_DDR_EN          3
`define AFR_BIT_OUT_INVERT      2
`define AFR_BIT_CLK_INVERT      7
`define AFR_BIT_DELAY_DISABLE   7
`define AFR_BIT_OVR_POS         1
`define AFR_BIT_OVR_EN          0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AFR_MAX_DELAY_PS        3200
`define AFR_MAX_DELAY_CODE      5'h1F

`endif

// file: core/afr_pkg.sv
/*
  Types for the converter function register bank. Assumes afr_cfg.svh
  carries every number.
*/
package afr_pkg;

   // -------------------------------------------------------------------
   // Chip operating modes
   // -------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      AFR_OP_NORMAL   = 3'h0,
      AFR_OP_PWRDOWN  = 3'h1,
      AFR_OP_STANDBY  = 3'h2,
      AFR_OP_NORMAL_B = 3'h3
   } afr_op_e;

   // -------------------------------------------------------------------
   // Output test patterns
   // -------------------------------------------------------------------
   typedef enum logic [3:0]
   {
      AFR_TP_OFF      = 4'h0,
      AFR_TP_MIDSCALE = 4'h1,
      AFR_TP_POS_FS   = 4'h2,
      AFR_TP_NEG_FS   = 4'h3,
      AFR_TP_CHECKER  = 4'h4,
      AFR_TP_PN23     = 4'h5,
      AFR_TP_PN9      = 4'h6,
      AFR_TP_TOGGLE   = 4'h7
   } afr_tp_e;

   typedef logic [7:0] afr_byte_t;

endpackage : afr_pkg

// file: core/afr_port_if.sv
/*
  Write port carrier between the register bank and its shadow stage.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps

interface afr_port_if;
   logic        wr_en;      // One-cycle write strobe.
   logic [7:0]  wr_addr;    // Register address.
   logic [7:0]  wr_data;    // Write data.
   logic        commit;     // One-cycle shadow commit pulse.

   modport src
   (
      output wr_en,
      output wr_addr,
      output wr_data,
      output commit
   );

   modport dst
   (
      input  wr_en,
      input  wr_addr,
      input  wr_data,
      input  commit
   );
endinterface : afr_port_if

// file: core/afr_shadow.sv
/*
  Shadow stage: holds the staged values of the shadowed registers until a
  commit pulse. Assumes the main bank decodes the transfer command.
*/
`timescale 1ns/1ps
`include "afr_cfg.svh"

module afr_shadow
(
   input  wire logic      clock,     // System clock.
   input  wire logic      rst,       // Asynchronous reset, active high.
   input  wire logic      clk_en,    // Freezes all state when low.
   afr_port_if.dst        port,      // Write and commit strobes.
   output logic [7:0]     stage [17] // Staged bytes, index addr-0x08.
);
   import afr_pkg::*;

   logic [7:0] next_stage [17];

   // -------------------------------------------------------------------
   // Staging writes
   // -------------------------------------------------------------------
   // A write lands only in staging; the active copy waits for the commit.
   always_comb
   begin
      next_stage = stage;
      if (port.wr_en && port.wr_addr >= `AFR_SHADOW_LO &&
          port.wr_addr <= `AFR_SHADOW_HI)
      begin
         next_stage[5'(port.wr_addr - `AFR_SHADOW_LO)] = port.wr_data;
      end
   end

   // staged defaults kept
   // Staging holds the reset defaults so a bare commit restores them. Delay
   // and range bytes have no default and keep what software last wrote, so
   // a later commit cannot wipe the value the active copy kept through reset.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 17; i++)
         begin
            if (i != 15 && i != 16)
            begin
               stage[i] <= 8'h00;
            end
         end
         stage[0]  <= `AFR_RST_POWER_MODES;
         stage[1]  <= `AFR_RST_CLOCK_CONTROL;
         stage[14] <= `AFR_RST_CLOCK_PHASE;
      end
      else if (clk_en)
      begin
         stage <= next_stage;
      end
   end

endmodule : afr_shadow

// file: tb/afr_bank_props.sv
/*
  Checker on the bank's top ports: commit timing, freeze, reads, defaults.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps

module afr_bank_props
(
   input wire logic        clock,        // Clock.
   input wire logic        rst,          // Reset.
   input wire logic        clk_en,       // Enable.
   input wire logic        wr_en,        // Write.
   input wire logic        rd_en,        // Read.
   input wire logic [7:0]  addr,         // Address.
   input wire logic [7:0]  wr_data,      // Data in.
   input afr_pkg::afr_byte_t rd_data,    // Data out.
   input afr_pkg::afr_tp_e test_pattern, // Pattern.
   input wire logic        test_active,  // Test on.
   input wire logic        dcs_enable,   // Stabilizer.
   input wire logic        ddr_enable,   // DDR mode.
   input wire logic        ovr_enable,   // Overrange on.
   input wire logic        ovr_alt_pins  // Pin pair.
);
   import afr_pkg::*;

   // A taken transfer command; active outputs follow one edge later.
   wire commit = clk_en && wr_en && addr == 8'hFF && wr_data == 8'h01;

   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);

   a_commit_only: assert property (!$stable(dcs_enable) |-> $past(commit, 2))
      else $error("stabilizer moved without a commit");
   a_ovr_direct: assert property (clk_en && wr_en && addr == 8'h2A ##1 clk_en
      |=> {7'h00, ovr_enable} == ($past(wr_data, 2) & 8'h01))
      else $error("overrange enable did not follow its write");
   a_alt_ddr: assert property (ovr_alt_pins |-> ddr_enable)
      else $error("alternate overrange pins outside DDR");
   a_test_flag: assert property (test_active == (test_pattern != AFR_TP_OFF))
      else $error("test flag disagrees with pattern");
   a_rst_dflt: assert property ($fell(rst) |-> dcs_enable && ovr_enable && !test_active)
      else $error("defaults missing after reset");
   a_freeze_hold: assert property (!clk_en |=> $stable(rd_data) && $stable(ovr_enable))
      else $error("state moved while frozen");
   a_read_hold: assert property (!(clk_en && rd_en) |=> $stable(rd_data))
      else $error("read data moved without a read");
   a_unmap_zero: assert property (clk_en && rd_en && (addr < 8'h08
      || (addr > 8'h18 && addr != 8'h2A)) |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
endmodule : afr_bank_props

bind afr_bank afr_bank_props chk_u
(
   .clock, .rst, .clk_en, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
   .test_pattern, .test_active, .dcs_enable, .ddr_enable, .ovr_enable,
   .ovr_alt_pins
);

// file: tb/afr_host.sv
/*
  Host model of the serial port side: single-byte register transfers,
  driven on the falling edge. Assumes the bench owns clk_en.
*/
`timescale 1ns/1ps

module afr_host
(
   input  wire logic         clock,   // Clock.
   input  afr_pkg::afr_byte_t rd_data, // Read data.
   output logic              wr_en,   // Write strobe.
   output logic              rd_en,   // Read strobe.
   output logic [7:0]        addr,    // Address.
   output logic [7:0]        wr_data  // Write data.
);
   import afr_pkg::*;

   // Idle lines start low.
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wr_data = 8'h00;
   end

   // One transfer held across one rising edge; afterwards the strobes drop and address and data flip
   // so a stale value is never mistaken for a live one.
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(negedge clock);
      wr_en = w;
      rd_en = ~w;
      addr = a;
      wr_data = d;
      @(negedge clock);
      q = rd_data;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = ~addr;
      wr_data = ~wr_data;
   endtask : xfer

   task automatic commit();
      logic [7:0] q;
      xfer(1'b1, 8'hFF, 8'h01, q);
      @(negedge clock);
   endtask : commit
endmodule : afr_host

// file: tb/adc_function_register_bank_tb.sv
/*
  Self-checking bench for the function register bank. Assumes the host
  model drives the register port and the checker is bound to the bank.
*/
`timescale 1ns/1ps

module adc_function_register_bank_tb;
   import afr_pkg::*;

   // ------------------------
   // Signals and instances
   // ------------------------
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic wr_en, rd_en, power_standby_select, dcs_enable, test_active, pn23_reset;
   logic pn9_reset, ain_disconnect, common_mode_output, drv_disable, ddr_enable;
   logic out_invert, dclk_invert, delay_enable, ovr_enable, ovr_alt_pins;
   logic [1:0] out_format;
   logic [3:0] lvds_drive;
   logic [4:0] delay_code, range_code;
   logic [7:0] addr, wr_data, d, q;
   logic [7:0] rb [6];
   logic [7:0] ua [6] = '{8'h0F, 8'h14, 8'h15, 8'h17, 8'h18, 8'h2A};
   logic [7:0] ra [8] = '{8'h08, 8'h09, 8'h0D, 8'h0F, 8'h14, 8'h15, 8'h16, 8'h2A};
   logic [7:0] rv [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01};
   logic [7:0] rc [3] = '{8'h10, 8'h00, 8'h0E};
   logic [31:0] seed = 32'h00012BA4;
   afr_byte_t rd_data;
   afr_tp_e test_pattern;
   afr_op_e op_mode;
   int bad_count = 0;
   int n_checks = 0;

   // Half period of 2.5 ns gives 200 MHz.
   always #2.5 clock = ~clock;

   afr_bank dut_u
   (
      .clock, .rst, .clk_en, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .op_mode,
      .power_standby_select, .dcs_enable, .test_pattern, .test_active, .pn23_reset,
      .pn9_reset, .ain_disconnect, .common_mode_output, .drv_disable, .ddr_enable,
      .out_invert, .out_format, .lvds_drive, .dclk_invert, .delay_enable,
      .delay_code, .range_code, .ovr_enable, .ovr_alt_pins
   );

   afr_host host_u (.clock, .rd_data, .wr_en, .rd_en, .addr, .wr_data);

   // ------------------------
   // Helpers
   // ------------------------
   task automatic chk(input string nm, input logic [7:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic finish_test();
      $display("TB: %0d checks, %0d mismatches", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // Eight steps per draw so consecutive bytes do not overlap.
   function automatic logic [7:0] rnd();
      repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction : rnd

   // Codes above seven are unused and read as off.
   function automatic logic [3:0] exp_tp(input logic [3:0] c);
      return c[3] ? 4'h0 : c;
   endfunction : exp_tp

   // ------------------------
   // Main sequence
   // ------------------------
   initial
   begin
      repeat (3) @(negedge clock);
      rst = 1'b0;
      chk("defaults", 8'hC0, {dcs_enable, ovr_enable, test_active, ain_disconnect,
          common_mode_output, dclk_invert, drv_disable, ddr_enable});
      chk("mode", 8'h00, {out_invert, out_format, op_mode});
      for (int i = 0; i < 8; i++)
      begin
         host_u.xfer(1'b0, ra[i], 8'h00, d);
         chk("reset value", rv[i], d);
      end
      $display("TB: defaults done");
      host_u.xfer(1'b1, 8'h09, 8'h00, q);
      host_u.xfer(1'b1, 8'h16, 8'h80, q);
      chk("held", 8'h02, {dcs_enable, dclk_invert});
      host_u.xfer(1'b0, 8'h09, 8'h00, d);
      chk("staged", 8'h00, d);
      host_u.commit();
      chk("applied", 8'h01, {dcs_enable, dclk_invert});
      host_u.xfer(1'b1, 8'h09, 8'h01, q);
      host_u.xfer(1'b1, 8'hFF, 8'h02, q);
      host_u.xfer(1'b0, 8'hFF, 8'h00, d);
      chk("transfer bit", 8'h00, {d[7:1], dcs_enable});
      host_u.commit();
      chk("dcs on", 8'h01, dcs_enable);
      $display("TB: commit done");
      host_u.xfer(1'b1, 8'h30, 8'hAA, q);
      host_u.xfer(1'b0, 8'h30, 8'h00, d);
      chk("unmapped", 8'h00, d);
      for (int i = 0; i < 20; i++)
      begin
         d = i < 4 ? {2'b00, i[0], 2'b00, i[2:0]} : (rnd() & 8'h30) | 8'(i - 4);
         host_u.xfer(1'b1, i < 4 ? 8'h08 : 8'h0D, d, q);
         host_u.commit();
         if (i < 4)
            chk("op mode", {d[5], 4'h0, d[2:0]}, {power_standby_select, 4'h0, op_mode});
         else
            chk("pattern", {d[5:4], exp_tp(d[3:0]) != 4'h0, 1'b0, exp_tp(d[3:0])},
                {pn23_reset, pn9_reset, test_active, 1'b0, test_pattern});
      end
      for (int i = 0; i < 24; i++)
      begin
         for (int j = 0; j < 6; j++)
         begin
            rb[j] = (i < 3 && j == 4) ? rc[i] : (i == 0 && j == 3) ? 8'h1F : rnd();
            host_u.xfer(1'b1, ua[j], rb[j], q);
         end
         host_u.commit();
         chk("ain", {6'h00, rb[0][2:1]}, {ain_disconnect, common_mode_output});
         chk("omode", {3'h0, rb[1][4:0]}, {drv_disable, ddr_enable, out_invert, out_format});
         chk("lvds", {4'h0, rb[2][3:0]}, {4'h0, lvds_drive});
         chk("delay", {2'h0, ~rb[3][7], rb[3][4:0]}, {2'h0, delay_enable, delay_code});
         chk("range", {3'h0, rb[4][4:0]}, {3'h0, range_code});
         chk("ovr", {6'h00, rb[5][1] & rb[1][3], rb[5][0]}, {ovr_alt_pins, ovr_enable});
      end
      $display("TB: fields done");
      d = {7'h00, ~ovr_enable};
      clk_en = 1'b0;
      host_u.xfer(1'b1, 8'h2A, d, q);
      chk("frozen", {7'h00, ~d[0]}, {7'h00, ovr_enable});
      clk_en = 1'b1;
      host_u.xfer(1'b1, 8'h09, 8'h00, q);
      host_u.commit();
      rst = 1'b1;
      @(negedge clock);
      chk("dcs reset", 8'h01, dcs_enable);
      rst = 1'b0;
      repeat (3) @(negedge clock);
      chk("range kept", {3'h0, rb[4][4:0]}, {3'h0, range_code});
      host_u.xfer(1'b0, 8'h18, 8'h00, d);
      chk("range staged", rb[4], d);
      host_u.xfer(1'b0, 8'h17, 8'h00, d);
      chk("delay staged", rb[3], d);
      host_u.xfer(1'b0, 8'h09, 8'h00, d);
      chk("dcs staged", 8'h01, d);
      host_u.commit();
      chk("range commit", {3'h0, rb[4][4:0]}, {3'h0, range_code});
      chk("dcs commit", 8'h01, {7'h00, dcs_enable});
      $display("TB: reset done");
      finish_test();
   end

   // Cut a hang short; the sequence needs far fewer cycles.
   initial
   begin
      repeat (20000) @(posedge clock);
      bad_count++;
      $display("CHECK FAILED watchdog expected end seen timeout");
      finish_test();
   end
endmodule : adc_function_register_bank_tb
